//--- common/diag_status_pkg.sv
// constants and types for the serial diagnostic status bytes
//------------------------------------------------------------------------
//------------------------------------------------------------------------
package diag_status_pkg;
  localparam int BYTE_W = 8;
  // response byte bit positions
  localparam int RSP_OUT_ON    = 0;
  localparam int RSP_ACTUATOR  = 1;
  localparam int RSP_INPUTS    = 4;
  localparam int RSP_LIMIT     = 5;
  localparam int RSP_WARNING   = 6;
  localparam int RSP_ERROR     = 7;
  // cause byte bit positions, shared by warning and error bytes
  localparam int CAUSE_OUT_A   = 0;
  localparam int CAUSE_OUT_B   = 1;
  localparam int CAUSE_CROSS   = 2;
  localparam int CAUSE_TEMP    = 3;
  localparam int CAUSE_ACTUATOR = 4;
  localparam int CAUSE_INTERNAL = 5;
  localparam int CAUSE_COMM    = 6;
  localparam int CAUSE_W       = 7;
  // request byte bit positions
  localparam int REQ_ERR_RESET = 7;
  // reset values
  localparam logic [7:0] BYTE_CLEAR = 8'h00;
  // switching states of the safety outputs
  typedef enum {OUT_OFF, OUT_ON} out_state_t;
endpackage

//--- core/cause_latch.sv
// latched error cause bits with priority of set over clear
`timescale 1ns/1ps
module cause_latch
  import diag_status_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               reset,
  // causes and clear
  input  wire logic [CAUSE_W-1:0] cause,
  input  wire logic               clearReq,
  // latched bits
  output logic      [CAUSE_W-1:0] latched
);
  // a cause present during the clear keeps its bit set
  always_ff @(posedge clk) begin
    if (reset) begin
      latched <= BYTE_CLEAR[CAUSE_W-1:0];
    end else if (clearReq) begin
      latched <= cause;
    end else begin
      latched <= latched | cause;
    end
  end
endmodule // cause_latch

//--- core/serial_diag_status.sv
// status, warning and error byte logic of the diagnostic channel
`timescale 1ns/1ps
module serial_diag_status
  import diag_status_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // request byte from the controller
  input  wire logic [BYTE_W-1:0] hostRequestByte,
  // sensor conditions
  input  wire logic              safetyInA,
  input  wire logic              safetyInB,
  input  wire logic              actuatorDetected,
  input  wire logic              limitArea,
  input  wire logic              guardOpen,
  input  wire logic              enableRequest,
  input  wire logic              commFail,
  // fault detectors, warning class and error class
  input  wire logic [CAUSE_W-1:0] warnCause,
  input  wire logic [CAUSE_W-1:0] errCause,
  input  wire logic              warnTimeout,
  // outputs to the controller
  output logic      [BYTE_W-1:0] sensorResponseByte,
  output logic      [BYTE_W-1:0] warningCauseByte,
  output logic      [BYTE_W-1:0] errorCauseByte,
  // safety outputs
  output logic                   safetyOutA,
  output logic                   safetyOutB
);
  //----------------------------------------------------------------------
  // error reset and latching
  //----------------------------------------------------------------------
  logic               prevReset;
  logic               resetFall;
  logic               prevGuard;
  logic               clearReq;
  logic [CAUSE_W-1:0] errAll;
  logic [CAUSE_W-1:0] errLatched;
  logic               errActive;
  logic               warnActive;
  out_state_t         outState;
  out_state_t         next_outState;

  // edge history of request bit 7 and guard
  always_ff @(posedge clk) begin
    if (reset) begin
      prevReset <= 1'b0;
      prevGuard <= 1'b0;
    end else begin
      prevReset <= hostRequestByte[REQ_ERR_RESET];
      prevGuard <= guardOpen;
    end
  end

  assign resetFall = prevReset & ~hostRequestByte[REQ_ERR_RESET];
  assign clearReq  = resetFall | (guardOpen & ~prevGuard);

  // communication failure is its own error cause
  always_comb begin
    errAll = errCause;
    errAll[CAUSE_COMM] = errCause[CAUSE_COMM] | commFail;
  end

  cause_latch u_latch (
    .clk     (clk),
    .reset   (reset),
    .cause   (errAll),
    .clearReq(clearReq),
    .latched (errLatched)
  );

  assign errActive  = |errLatched;
  assign warnActive = |warnCause;

  //----------------------------------------------------------------------
  // safety output control
  //----------------------------------------------------------------------
  always_comb begin
    next_outState = outState;
    if (commFail) begin
      next_outState = outState;
    end else if (errActive || warnTimeout || !enableRequest) begin
      next_outState = OUT_OFF;
    end else if (actuatorDetected && safetyInA && safetyInB) begin
      next_outState = OUT_ON;
    end else begin
      next_outState = OUT_OFF;
    end
  end

  // output state register
  always_ff @(posedge clk) begin
    if (reset) begin
      outState <= OUT_OFF;
    end else begin
      outState <= next_outState;
    end
  end

  // both safety outputs follow the next state so the status byte agrees
  always_ff @(posedge clk) begin
    if (reset) begin
      safetyOutA <= 1'b0;
      safetyOutB <= 1'b0;
    end else begin
      safetyOutA <= (next_outState == OUT_ON);
      safetyOutB <= (next_outState == OUT_ON);
    end
  end

  //----------------------------------------------------------------------
  // status bytes
  //----------------------------------------------------------------------
  // true when a switching state drives the safety outputs
  function automatic logic isOn(input out_state_t s);
    return (s == OUT_ON);
  endfunction

  logic [BYTE_W-1:0] next_response;
  always_comb begin
    next_response = BYTE_CLEAR;
    next_response[RSP_OUT_ON]   = isOn(next_outState);
    next_response[RSP_ACTUATOR] = actuatorDetected;
    next_response[RSP_INPUTS]   = safetyInA & safetyInB;
    next_response[RSP_LIMIT]    = actuatorDetected & limitArea
                                  & isOn(next_outState);
    next_response[RSP_WARNING]  = warnActive | errActive;
    next_response[RSP_ERROR]    = errActive & ~isOn(next_outState);
  end

  // registered bytes, all bits active high
  always_ff @(posedge clk) begin
    if (reset) begin
      sensorResponseByte <= BYTE_CLEAR;
      warningCauseByte   <= BYTE_CLEAR;
      errorCauseByte     <= BYTE_CLEAR;
    end else begin
      sensorResponseByte <= next_response;
      warningCauseByte   <= {1'b0, warnCause};
      errorCauseByte     <= {1'b0, errLatched};
    end
  end

  //----------------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------------
  a_error_detail: assert property (@(posedge clk) disable iff (reset)
    sensorResponseByte[RSP_ERROR] |-> (errorCauseByte != BYTE_CLEAR))
    else $error("error flagged without cause");
  a_out_bit: assert property (@(posedge clk) disable iff (reset)
    sensorResponseByte[RSP_OUT_ON] == safetyOutA)
    else $error("output bit disagrees with output");
  a_inputs_live: assert property (@(posedge clk) disable iff (reset)
    (safetyInA && safetyInB) |=> sensorResponseByte[RSP_INPUTS])
    else $error("inputs bit missing");
  a_comm_hold: assert property (@(posedge clk) disable iff (reset)
    commFail |=> $stable(safetyOutA) or !$past(commFail))
    else $error("output moved during comm fail");
  a_comm_report: assert property (@(posedge clk) disable iff (reset)
    commFail |-> ##2 errorCauseByte[CAUSE_COMM])
    else $error("comm failure not reported");
  a_warn_follow: assert property (@(posedge clk) disable iff (reset)
    ##1 warningCauseByte[CAUSE_W-1:0] == $past(warnCause))
    else $error("warning byte not following cause");
  a_err_latch: assert property (@(posedge clk) disable iff (reset)
    (errLatched[CAUSE_TEMP] && !clearReq) |=> errLatched[CAUSE_TEMP])
    else $error("error bit dropped without reset");
  a_err_off: assert property (@(posedge clk) disable iff (reset)
    sensorResponseByte[RSP_ERROR] |-> !safetyOutA && !safetyOutB)
    else $error("error with outputs on");
  a_limit_bit: assert property (@(posedge clk) disable iff (reset)
    sensorResponseByte[RSP_LIMIT] |-> sensorResponseByte[RSP_OUT_ON])
    else $error("limit bit with outputs off");

  //----------------------------------------------------------------------
  // output switching checks
  //----------------------------------------------------------------------
  // the two safety outputs always switch as a pair
  a_outs_agree: assert property (@(posedge clk) disable iff (reset)
    safetyOutA == safetyOutB)
    else $error("safety outputs disagree");

  // outputs only come on with actuator, both inputs and enable
  a_on_needs: assert property (@(posedge clk) disable iff (reset)
    $rose(safetyOutA) |-> $past(actuatorDetected && safetyInA && safetyInB && enableRequest))
    else $error("outputs on without their conditions");

  // a withdrawn enable switches off unless the link is down
  a_off_no_enable: assert property (@(posedge clk) disable iff (reset)
    (!enableRequest && !commFail) |=> !safetyOutA)
    else $error("outputs on without enable");

  // an expired warning timer ends the delayed switch-off
  a_warn_timeout: assert property (@(posedge clk) disable iff (reset)
    (warnTimeout && !commFail) |=> !safetyOutA)
    else $error("outputs on after warning timeout");

  // a latched error switches off unless the link is down
  a_err_outs_off: assert property (@(posedge clk) disable iff (reset)
    (errActive && !commFail) |=> !safetyOutA)
    else $error("outputs on with latched error");

  // output b is frozen as well while the link is down
  a_comm_hold_b: assert property (@(posedge clk) disable iff (reset)
    commFail |=> $stable(safetyOutB))
    else $error("output b moved during comm fail");

  //----------------------------------------------------------------------
  // response byte checks
  //----------------------------------------------------------------------
  // actuator bit follows its detector one cycle later
  a_actuator_bit: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> (sensorResponseByte[RSP_ACTUATOR] == $past(actuatorDetected)))
    else $error("actuator bit wrong");

  // inputs bit drops when either input is dead
  a_inputs_dead: assert property (@(posedge clk) disable iff (reset)
    !(safetyInA && safetyInB) |=> !sensorResponseByte[RSP_INPUTS])
    else $error("inputs bit set with dead input");

  // limit bit needs a detected actuator
  a_limit_act: assert property (@(posedge clk) disable iff (reset)
    sensorResponseByte[RSP_LIMIT] |-> sensorResponseByte[RSP_ACTUATOR])
    else $error("limit bit without actuator");

  // limit bit set when actuated in the limit area with outputs on
  a_limit_set: assert property (@(posedge clk) disable iff (reset)
    (actuatorDetected && limitArea && isOn(next_outState)) |=> sensorResponseByte[RSP_LIMIT])
    else $error("limit bit missing");

  // an active warning cause raises the warning bit
  a_warn_bit: assert property (@(posedge clk) disable iff (reset)
    (warningCauseByte != BYTE_CLEAR) |-> sensorResponseByte[RSP_WARNING])
    else $error("warning bit missing");

  // an error is always a warning as well
  a_err_is_warn: assert property (@(posedge clk) disable iff (reset)
    sensorResponseByte[RSP_ERROR] |-> sensorResponseByte[RSP_WARNING])
    else $error("error without warning bit");

  //----------------------------------------------------------------------
  // cause byte checks
  //----------------------------------------------------------------------
  // a flagged warning or error always has a cause to read out
  a_warn_detail: assert property (@(posedge clk) disable iff (reset)
    sensorResponseByte[RSP_WARNING]
      |-> ((warningCauseByte != BYTE_CLEAR) || (errorCauseByte != BYTE_CLEAR)))
    else $error("warning flagged without cause");

  // unused top bit of both cause bytes stays clear
  a_cause_top: assert property (@(posedge clk) disable iff (reset)
    !warningCauseByte[BYTE_W-1] && !errorCauseByte[BYTE_W-1])
    else $error("unused cause bit set");

  // warning byte drops as soon as the causes are gone
  a_warn_gone: assert property (@(posedge clk) disable iff (reset)
    (warnCause == '0) |=> (warningCauseByte == BYTE_CLEAR))
    else $error("warning byte held without cause");

  // a link failure lands in the latch on the next edge
  a_comm_latched: assert property (@(posedge clk) disable iff (reset)
    commFail |=> errLatched[CAUSE_COMM])
    else $error("comm failure not latched");

  // latched bits never drop without a clear event
  a_err_sticky: assert property (@(posedge clk) disable iff (reset)
    !clearReq |=> ((errLatched & $past(errLatched)) == $past(errLatched)))
    else $error("latched error dropped");

  //----------------------------------------------------------------------
  // error reset checks
  //----------------------------------------------------------------------
  // a fall of request bit 7 is a clear event
  a_reset_fall: assert property (@(posedge clk) disable iff (reset)
    ##1 ($past(hostRequestByte[REQ_ERR_RESET]) && !hostRequestByte[REQ_ERR_RESET])
      |-> clearReq)
    else $error("request fall not seen");

  // opening the guard is a clear event
  a_guard_clear: assert property (@(posedge clk) disable iff (reset)
    $rose(guardOpen) |-> clearReq)
    else $error("guard opening not seen");

  // a clear with no cause left empties the latch
  a_clear_gone: assert property (@(posedge clk) disable iff (reset)
    (clearReq && (errAll == '0)) |=> (errLatched == '0))
    else $error("error not cleared");

  // a cause present during the clear keeps its bit
  a_clear_keeps: assert property (@(posedge clk) disable iff (reset)
    clearReq |=> ((errLatched & $past(errAll)) == $past(errAll)))
    else $error("present cause lost on clear");

  //----------------------------------------------------------------------
  // cover points
  //----------------------------------------------------------------------
  c_outputs_on: cover property (@(posedge clk) disable iff (reset) $rose(safetyOutA));
  c_error_set:  cover property (@(posedge clk) disable iff (reset)
    $rose(sensorResponseByte[RSP_ERROR]));
  c_err_clear:  cover property (@(posedge clk) disable iff (reset) resetFall ##2
    (errorCauseByte == BYTE_CLEAR));
  c_comm_fail:  cover property (@(posedge clk) disable iff (reset) commFail && safetyOutA);
  c_warn_stop:  cover property (@(posedge clk) disable iff (reset)
    warnTimeout && safetyOutA);
endmodule // serial_diag_status

//--- testbench/diag_gateway_model.sv
// gateway-side model: drives the request byte and the link state
`timescale 1ns/1ps
module diag_gateway_model (
  // clock
  input  wire logic       clk,
  // commands from the bench
  input  wire logic       resetPulse,
  input  wire logic       linkDown,
  // request side of the channel
  output logic      [7:0] hostRequestByte = 8'h00,
  output logic            commFail = 1'b0
);
  // error reset: bit 7 follows resetPulse one edge later and falls with it
  always_ff @(posedge clk) begin
    hostRequestByte <= {resetPulse, 7'h00};
    commFail        <= linkDown;
  end
endmodule // diag_gateway_model

//--- testbench/serial_diag_status_tb.sv
// self-checking bench for the diagnostic status bytes
`timescale 1ns/1ps
module serial_diag_status_tb;
  import diag_status_pkg::*;
  logic               clk = 1'b0;
  logic               reset = 1'b1;
  logic               inA = 0, inB = 0, act = 0, lim = 0, guard = 0, en = 0;
  logic               wTo = 0, rstPulse = 0, linkDown = 0, comm, outA, outB;
  logic [CAUSE_W-1:0] wCause = '0, eCause = '0;
  logic [BYTE_W-1:0]  req, rsp, warnB, errB, exp;
  int                 n_fail = 0;
  int                 compares = 0;
  // free-running 250 MHz clock
  initial begin
    forever #2 clk = ~clk;
  end
  diag_gateway_model GW (.clk(clk), .resetPulse(rstPulse), .linkDown(linkDown),
    .hostRequestByte(req), .commFail(comm));
  serial_diag_status DUT (.clk(clk), .reset(reset), .hostRequestByte(req),
    .safetyInA(inA), .safetyInB(inB), .actuatorDetected(act), .limitArea(lim),
    .guardOpen(guard), .enableRequest(en), .commFail(comm), .warnCause(wCause),
    .errCause(eCause), .warnTimeout(wTo), .sensorResponseByte(rsp),
    .warningCauseByte(warnB), .errorCauseByte(errB), .safetyOutA(outA),
    .safetyOutB(outB));
  // advance n edges, then move off the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // byte compare
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    compares++;
    if (got !== want) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  // verdict and end of run
  task automatic complete_run();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // bounded wait for the latched error byte to clear
  task automatic wait_clear();
    int k;
    for (k = 0; k < 8 && errB !== 8'h00; k++) step(1);
    if (errB !== 8'h00) begin
      n_fail++;
      $display("CHECK FAILED at %0t: error byte never cleared", $time);
      complete_run();
    end
  endtask
  // main sequence
  initial begin
    step(8);
    reset = 1'b0;
    step(2);
    chk(rsp, 8'h00);
    chk(errB, 8'h00);
    inA = 1;
    inB = 1;
    step(3);
    chk(rsp, 8'h10);
    act = 1;
    en = 1;
    step(3);
    chk(rsp, 8'h13);
    chk({6'h00, outA, outB}, 8'h03);
    lim = 1;
    step(3);
    chk(rsp, 8'h33);
    lim = 0;
    $display("test status done");
    wCause = 7'h08;
    step(3);
    chk(warnB, 8'h08);
    chk(rsp, 8'h53);
    wCause = 7'h00;
    step(3);
    chk(warnB, 8'h00);
    wCause = 7'h01;
    wTo = 1;
    step(3);
    chk(warnB, 8'h01);
    chk(rsp, 8'h52);
    chk({6'h00, outA, outB}, 8'h00);
    wTo = 0;
    wCause = 7'h00;
    step(3);
    chk(rsp, 8'h13);
    $display("test warning done");
    for (int i = 0; i < 4; i++) begin
      exp = 8'h01 << i;
      eCause = exp[6:0];
      step(3);
      chk(errB, exp);
      chk(rsp, 8'hD2);
      chk({6'h00, outA, outB}, 8'h00);
      rstPulse = 1;
      step(1);
      rstPulse = 0;
      step(3);
      chk(errB, exp);
      eCause = 7'h00;
      step(3);
      chk(errB, exp);
      if (i == 3) guard = 1;
      else rstPulse = 1;
      step(1);
      guard = 0;
      rstPulse = 0;
      wait_clear();
      step(3);
      chk(rsp, 8'h13);
    end
    $display("test errors done");
    linkDown = 1;
    step(3);
    en = 0;
    step(3);
    chk({6'h00, outA, outB}, 8'h03);
    linkDown = 0;
    step(3);
    chk({6'h00, outA, outB}, 8'h00);
    $display("test link done");
    complete_run();
  end
endmodule // serial_diag_status_tb
